// ### sfc_pkg.sv
// Purpose: shared constants for the sample fifo control block
// Assumes: byte-wide register port, one clock
// Notes:   offsets are register addresses on the device register port
`default_nettype none
package sfc_pkg;
  localparam logic [7:0] ADDR_STATUS     = 8'h00;
  localparam logic [7:0] ADDR_WR_SLOT    = 8'h04;
  localparam logic [7:0] ADDR_RD_SLOT    = 8'h05;
  localparam logic [7:0] ADDR_FILL_HI    = 8'h06;
  localparam logic [7:0] ADDR_FILL_LO    = 8'h07;
  localparam logic [7:0] ADDR_POP        = 8'h08;
  localparam logic [7:0] ADDR_MARGIN     = 8'h09;
  localparam logic [7:0] ADDR_CTRL       = 8'h0A;
  localparam logic [7:0] RST_MARGIN      = 8'h7F;
  localparam logic [6:0] LOSS_MAX        = 7'h7F;
  localparam int         CTRL_PURGE      = 4;
  localparam int         CTRL_CLR_POP    = 3;
  localparam int         CTRL_REPEAT     = 2;
  localparam int         CTRL_OVERWRITE  = 1;
  localparam int         STAT_NEAR_FULL  = 7;
  localparam int         STAT_DATA_WAIT  = 6;
  localparam int         STAT_FRAME_DONE = 3;
  localparam logic       RST_CLR_POP     = 1'b1;
  localparam int         FIFO_DEPTH      = 16;
  localparam int         SLOT_COUNT      = 256;
endpackage : sfc_pkg
`default_nettype wire

// ### sfc_stage_fifo.sv
// Purpose: small parameterised staging fifo for incoming samples
// Assumes: single clock, clock enable freezes all state
// Notes:   honest full and empty; ready drops when full
`default_nettype none
module sfc_stage_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wp_ff;
  logic [AW-1:0]    rp_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rp_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage, written only, no reset needed for data
  always_ff @(posedge clk_sys) begin
    if (clk_en && push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end

  // pointers and occupancy; wrap relies on power-of-two depth
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else if (clk_en) begin
      if (push) wp_ff <= wp_ff + 1'b1;
      if (pop)  rp_ff <= rp_ff + 1'b1;
      if (push && !pop) cnt_ff <= cnt_ff + 1'b1;
      else if (pop && !push) cnt_ff <= cnt_ff - 1'b1;
    end
  end
endmodule : sfc_stage_fifo
`default_nettype wire

// ### sfc_sample_fifo_control.sv
// Purpose: circular sample store with host registers, fill level and loss tally
// Assumes: byte register port synchronous to clk_sys, one access per strobe
// Notes:   samples enter through a staging fifo, one byte slot per sample
//          a purge empties the circular store and clears the loss tally; samples still waiting
//          in the staging fifo move into the store once the purge is over
//          read data comes one cycle after its strobe and holds until the
//          next read, so the host may take it any time before then
`default_nettype none
module sfc_sample_fifo_control #(
  parameter int SLOTS      = sfc_pkg::SLOT_COUNT,
  parameter int STAGE_DEEP = sfc_pkg::FIFO_DEPTH
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       smp_valid,
  input  wire logic [7:0] smp_data,
  output logic            smp_ready,
  input  wire logic       frame_done,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  output logic            near_full_flag,
  output logic            data_wait_flag,
  output logic            frame_done_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [1:0] {
    SFC_IDLE  = 2'b01,
    SFC_STORE = 2'b10
  } sfc_state_t;

  sfc_state_t  state_ff;
  logic [7:0]  slot_ff [SLOTS];
  logic [7:0]  wr_idx_ff;
  logic [7:0]  rd_idx_ff;
  logic [8:0]  fill_ff;
  logic [6:0]  loss_ff;
  logic [7:0]  margin_ff;
  logic        clr_pop_ff;
  logic        repeat_ff;
  logic        overwrite_ff;
  logic        purge_ff;
  logic        nf_ff;
  logic        dw_ff;
  logic        fd_ff;
  logic        nf_cond_ff;
  logic [7:0]  rdata_ff;
  logic        smp_ready_ff;
  logic        stored_ff;

  logic        st_valid;
  logic        st_ready;
  logic [7:0]  st_data;
  logic        stage_in_ready;

  ////////////////////////////////////////////////////////////////////////////
  // staging fifo between the engine and the circular store
  // its ready is the only back-pressure the engine ever sees
  sfc_stage_fifo #(
    .WIDTH (8),
    .DEPTH (STAGE_DEEP)
  ) u_stage (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .in_valid  (smp_valid),
    .in_ready  (stage_in_ready),
    .in_data   (smp_data),
    .out_valid (st_valid),
    .out_ready (st_ready),
    .out_data  (st_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode
  // writes to read-only places are ignored simply by not decoding them
  logic        full;
  logic        wr_hit_rd;
  logic        wr_hit_margin;
  logic        wr_hit_ctrl;
  logic        rd_pop;
  logic        rd_status;
  logic        pop;
  logic        take;
  logic        store;
  logic        lose;
  logic        drop_old;
  logic [8:0]  free_slots;
  logic        nf_now;
  logic        clear_flags;

  // the indices meet both when empty and when full, so fullness is
  // judged from the fill level alone
  assign full          = (fill_ff == 9'(SLOTS));
  assign wr_hit_rd     = reg_wr && (reg_addr == sfc_pkg::ADDR_RD_SLOT);
  assign wr_hit_margin = reg_wr && (reg_addr == sfc_pkg::ADDR_MARGIN);
  assign wr_hit_ctrl   = reg_wr && (reg_addr == sfc_pkg::ADDR_CTRL);
  assign rd_pop        = reg_rd && (reg_addr == sfc_pkg::ADDR_POP);
  assign rd_status     = reg_rd && (reg_addr == sfc_pkg::ADDR_STATUS);
  // a pop of an empty store returns zero and moves nothing
  assign pop           = rd_pop && (fill_ff != 9'h000);
  // a sample is taken from staging only in the store state, never during purge
  assign st_ready      = (state_ff == SFC_STORE) && !purge_ff;
  assign take          = st_valid && st_ready;
  // a pop the same cycle frees a slot, so a sample is not counted lost;
  // with overwrite off a full store still drains staging, the sample lost
  assign store         = take && (!full || pop || overwrite_ff);
  assign lose          = take && full && !pop;
  assign drop_old      = take && full && !pop && overwrite_ff;
  // nine-bit compare so 256 free slots never alias onto a small margin;
  // a margin of zero asks for a completely full store
  assign free_slots    = 9'(SLOTS) - fill_ff;
  assign nf_now        = (free_slots <= {1'b0, margin_ff});
  // a status read always clears; a pop clears only with the select set
  assign clear_flags   = rd_status || (rd_pop && clr_pop_ff);

  ////////////////////////////////////////////////////////////////////////////
  // control state machine: idle after reset, store once running
  // the idle cycle keeps the store shut on the first edge after reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= SFC_IDLE;
    end else if (clk_en) begin
      case (state_ff)
        SFC_IDLE:  state_ff <= SFC_STORE;
        SFC_STORE: state_ff <= SFC_STORE;
        default:   state_ff <= SFC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample storage
  // no reset on sample data: a slot is only read behind the fill level
  always_ff @(posedge clk_sys) begin
    if (clk_en && store) begin
      slot_ff[wr_idx_ff] <= st_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write slot index; 8-bit natural wrap makes the store circular
  // refused samples leave it alone, so it names the slot the next one fills
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_idx_ff <= 8'h00;
    end else if (clk_en) begin
      if (purge_ff) begin
        wr_idx_ff <= 8'h00;
      end else if (store) begin
        wr_idx_ff <= wr_idx_ff + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read slot index; host write wins over pop, drop of oldest advances it
  // a host write in the same cycle as a pop still returns the popped byte,
  // but the index lands where the host put it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_idx_ff <= 8'h00;
    end else if (clk_en) begin
      if (purge_ff) begin
        rd_idx_ff <= 8'h00;
      end else if (wr_hit_rd) begin
        rd_idx_ff <= reg_wdata;
      end else if (pop || drop_old) begin
        rd_idx_ff <= rd_idx_ff + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fill level; a rewritten read index does not alter it, so rereads
  // leave the count as the host last saw it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fill_ff <= 9'h000;
    end else if (clk_en) begin
      if (purge_ff) begin
        fill_ff <= 9'h000;
      end else if (store && !pop && !drop_old) begin
        fill_ff <= fill_ff + 9'h001;
      end else if (pop && !store) begin
        fill_ff <= fill_ff - 9'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lost-sample tally, saturating
  // both losses count: a refused new sample or an overwritten old one;
  // a purge clears it too, so a fresh run starts from zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      loss_ff <= 7'h00;
    end else if (clk_en) begin
      if (purge_ff) begin
        loss_ff <= 7'h00;
      end else if (lose && (loss_ff != sfc_pkg::LOSS_MAX)) begin
        loss_ff <= loss_ff + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers; purge bit self-clears after one cycle
  // the purge bit reads back as one only in the cycle in which it acts
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      margin_ff    <= sfc_pkg::RST_MARGIN;
      clr_pop_ff   <= sfc_pkg::RST_CLR_POP;
      repeat_ff    <= 1'b0;
      overwrite_ff <= 1'b0;
      purge_ff     <= 1'b0;
    end else if (clk_en) begin
      if (wr_hit_margin) margin_ff <= reg_wdata;
      if (wr_hit_ctrl) begin
        clr_pop_ff   <= reg_wdata[sfc_pkg::CTRL_CLR_POP];
        repeat_ff    <= reg_wdata[sfc_pkg::CTRL_REPEAT];
        overwrite_ff <= reg_wdata[sfc_pkg::CTRL_OVERWRITE];
        purge_ff     <= reg_wdata[sfc_pkg::CTRL_PURGE];
      end else begin
        purge_ff     <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle echo of a stored sample; by then the fill level counts it,
  // so repeat select 0 judges the near-full condition on the new level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stored_ff <= 1'b0;
    end else if (clk_en) begin
      stored_ff <= store;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags; a setting event wins over a clear in the same cycle
  // repeat select 0 sets again after each stored sample while near full,
  // repeat select 1 sets once on the rising edge of the condition
  logic nf_set;
  assign nf_set = repeat_ff ? (nf_now && !nf_cond_ff)
                            : (nf_now && stored_ff);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      nf_ff      <= 1'b0;
      dw_ff      <= 1'b0;
      fd_ff      <= 1'b0;
      nf_cond_ff <= 1'b0;
    end else if (clk_en) begin
      nf_cond_ff <= nf_now;
      if (nf_set) nf_ff <= 1'b1;
      else if (clear_flags) nf_ff <= 1'b0;
      if (store) dw_ff <= 1'b1;
      else if (clear_flags) dw_ff <= 1'b0;
      if (frame_done) fd_ff <= 1'b1;
      else if (clear_flags) fd_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, registered one cycle after the read strobe
  // unmapped addresses read zero, as do status bits beyond the three flags
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (clk_en && reg_rd) begin
      if (reg_addr == sfc_pkg::ADDR_STATUS) begin
        rdata_ff <= 8'h00;
        rdata_ff[sfc_pkg::STAT_NEAR_FULL]  <= nf_ff;
        rdata_ff[sfc_pkg::STAT_DATA_WAIT]  <= dw_ff;
        rdata_ff[sfc_pkg::STAT_FRAME_DONE] <= fd_ff;
      end else if (reg_addr == sfc_pkg::ADDR_WR_SLOT) begin
        rdata_ff <= wr_idx_ff;
      end else if (reg_addr == sfc_pkg::ADDR_RD_SLOT) begin
        rdata_ff <= rd_idx_ff;
      end else if (reg_addr == sfc_pkg::ADDR_FILL_HI) begin
        rdata_ff <= {fill_ff[8], loss_ff};
      end else if (reg_addr == sfc_pkg::ADDR_FILL_LO) begin
        rdata_ff <= fill_ff[7:0];
      end else if (reg_addr == sfc_pkg::ADDR_POP) begin
        rdata_ff <= (fill_ff != 9'h000) ? slot_ff[rd_idx_ff] : 8'h00;
      end else if (reg_addr == sfc_pkg::ADDR_MARGIN) begin
        rdata_ff <= margin_ff;
      end else if (reg_addr == sfc_pkg::ADDR_CTRL) begin
        rdata_ff <= 8'h00;
        rdata_ff[sfc_pkg::CTRL_CLR_POP]   <= clr_pop_ff;
        rdata_ff[sfc_pkg::CTRL_REPEAT]    <= repeat_ff;
        rdata_ff[sfc_pkg::CTRL_OVERWRITE] <= overwrite_ff;
        rdata_ff[sfc_pkg::CTRL_PURGE]     <= purge_ff;
      end else begin
        rdata_ff <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered copy of staging ready, so the output comes from a flop
  // it lags the staging fifo by a cycle; an engine must not push twice
  // on the strength of a single high ready
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      smp_ready_ff <= 1'b0;
    end else if (clk_en) begin
      smp_ready_ff <= stage_in_ready;
    end
  end

  assign smp_ready       = smp_ready_ff;
  assign reg_rdata       = rdata_ff;
  assign near_full_flag  = nf_ff;
  assign data_wait_flag  = dw_ff;
  assign frame_done_flag = fd_ff;
endmodule : sfc_sample_fifo_control
`default_nettype wire

// ### sfc_props.sv
// Purpose: port checker for the sample fifo control block
// Assumes: one clock, asynchronous active-low reset
// Notes:   clear-on-pop select is mirrored from host writes
`default_nettype none
module sfc_props (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       clk_en,
  input wire logic       frame_done,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       near_full_flag,
  input wire logic       frame_done_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic rd_ok;
  logic wr_ok;
  logic clr_pop_ff;
  assign rd_ok = reg_rd && clk_en;
  assign wr_ok = reg_wr && clk_en;
  // mirror of the select; pop side effects cannot be judged without it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clr_pop_ff <= sfc_pkg::RST_CLR_POP;
    end else if (wr_ok && reg_addr == sfc_pkg::ADDR_CTRL) begin
      clr_pop_ff <= reg_wdata[sfc_pkg::CTRL_CLR_POP];
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // write, one idle cycle, then read of the same place
  property p_readback(logic [7:0] a);
    (wr_ok && reg_addr == a) ##1 !(rd_ok || wr_ok) ##1 (rd_ok && reg_addr == a)
      |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_margin_readback: assert property (p_readback(sfc_pkg::ADDR_MARGIN))
    else $error("margin readback differs");
  a_rdslot_readback: assert property (p_readback(sfc_pkg::ADDR_RD_SLOT))
    else $error("read slot readback differs");
  a_purge_self_clear: assert property ((wr_ok && reg_addr == sfc_pkg::ADDR_CTRL
    && reg_wdata[sfc_pkg::CTRL_PURGE]) ##1 !(rd_ok || wr_ok) ##1
    (rd_ok && reg_addr == sfc_pkg::ADDR_CTRL) |=> !reg_rdata[sfc_pkg::CTRL_PURGE])
    else $error("purge bit did not clear");
  a_pop_keeps_flag: assert property (rd_ok && reg_addr == sfc_pkg::ADDR_POP
    && !clr_pop_ff && frame_done_flag |=> frame_done_flag)
    else $error("pop cleared flag while select is 0");
  a_pop_clears_flag: assert property (rd_ok && reg_addr == sfc_pkg::ADDR_POP
    && clr_pop_ff && !frame_done |=> !frame_done_flag)
    else $error("pop left flag set while select is 1");
  a_status_clears: assert property (rd_ok && reg_addr == sfc_pkg::ADDR_STATUS
    && !frame_done |=> !frame_done_flag)
    else $error("status read left flag set");
  a_tally_no_wrap: assert property ((rd_ok && reg_addr == sfc_pkg::ADDR_FILL_HI)
    ##1 (rd_ok && reg_addr == sfc_pkg::ADDR_FILL_HI)
    |=> reg_rdata[6:0] >= $past(reg_rdata[6:0]))
    else $error("loss tally went down");
  a_wrslot_step: assert property ((rd_ok && reg_addr == sfc_pkg::ADDR_WR_SLOT)
    ##1 (rd_ok && reg_addr == sfc_pkg::ADDR_WR_SLOT)
    |=> 8'(reg_rdata - $past(reg_rdata)) <= 8'h01)
    else $error("write slot jumped");
  a_rdata_holds: assert property (!rd_ok |=> $stable(reg_rdata))
    else $error("read data changed without read");
  c_pop_flag: cover property (rd_ok && reg_addr == sfc_pkg::ADDR_POP && frame_done_flag);
  c_purge: cover property (wr_ok && reg_addr == sfc_pkg::ADDR_CTRL
    && reg_wdata[sfc_pkg::CTRL_PURGE]);
  c_near_full: cover property ($rose(near_full_flag));
endmodule : sfc_props
bind sfc_sample_fifo_control sfc_props chk_u (.clk_sys, .rst_n, .clk_en, .frame_done,
  .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .near_full_flag, .frame_done_flag);
`default_nettype wire

// ### sfc_host_model.sv
// Purpose: host processor model on the register port
// Assumes: strobes launched on rising edges, one access per strobe
// Notes:   released address and data show the inverse of the last value
`default_nettype none
module sfc_host_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] reg_rdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////////
  // one write; the bench never rewinds the read slot near full
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  // one read, or two back to back; data taken on the falling edge half a cycle after each read edge
  task automatic rd(input logic [7:0] a, input logic two, output logic [7:0] d0,
                    output logic [7:0] d1);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= two;
    if (!two) reg_addr <= ~a;
    @(negedge clk_sys);
    d0 = reg_rdata;
    d1 = d0;
    if (two) begin
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      @(negedge clk_sys);
      d1 = reg_rdata;
    end
  endtask : rd
endmodule : sfc_host_model
`default_nettype wire

// ### sfc_sample_fifo_control_test.sv
// Purpose: self-checking bench for the sample fifo control block
// Assumes: 20 MHz clock, samples offered every other cycle at most
// Notes:   expected values follow the register rules, never the design
`default_nettype none
module sfc_sample_fifo_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk_sys = 1'b0;
  logic       rst_n;
  logic       smp_valid;
  logic [7:0] smp_data;
  logic       smp_ready;
  logic       frame_done;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       near_full_flag;
  logic       data_wait_flag;
  logic       frame_done_flag;
  logic [7:0] nxt_smp = 8'hA0;
  int         mismatches = 0;
  int         cmp_count = 0;
  always #25 clk_sys = ~clk_sys;
  sfc_sample_fifo_control dut_u (.clk_sys, .rst_n, .clk_en(1'b1), .smp_valid, .smp_data,
    .smp_ready, .frame_done, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .near_full_flag, .data_wait_flag, .frame_done_flag);
  sfc_host_model host_u (.clk_sys, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic two, input logic [7:0] exp);
    logic [7:0] d0, d1;
    host_u.rd(a, two, d0, d1);
    chk(d0, exp);
    chk(d1, exp);
  endtask : rchk
  // samples spaced two cycles apart, so the staging fifo never backs up
  task automatic push(input int n);
    int guard;
    for (int i = 0; i < n; i++) begin
      guard = 0;
      @(negedge clk_sys);
      while (smp_ready !== 1'b1 && guard < 50) begin
        @(negedge clk_sys);
        guard++;
      end
      chk({7'h00, smp_ready}, 8'h01);
      @(posedge clk_sys);
      smp_valid <= 1'b1;
      smp_data  <= nxt_smp;
      nxt_smp++;
      @(posedge clk_sys);
      smp_valid <= 1'b0;
      smp_data  <= ~nxt_smp;
    end
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : push
  task automatic pulse_frame();
    @(posedge clk_sys);
    frame_done <= 1'b1;
    @(posedge clk_sys);
    frame_done <= 1'b0;
  endtask : pulse_frame
  //////////////////////////////////////////////////////////////////////////////
  task automatic sc_reset_values();
    for (int a = 4; a <= 10; a++) begin
      rchk(8'(a), 1'b0, a == 9 ? 8'h7F : a == 10 ? 8'h08 : 8'h00);
    end
    rchk(8'h0B, 1'b0, 8'h00);
  endtask : sc_reset_values
  task automatic sc_push_pop();
    logic [7:0] b;
    b = nxt_smp;
    push(3);
    rchk(8'h04, 1'b0, 8'h03);
    rchk(8'h07, 1'b0, 8'h03);
    rchk(8'h08, 1'b0, b);
    rchk(8'h08, 1'b0, 8'(b + 1));
    rchk(8'h05, 1'b0, 8'h02);
    rchk(8'h07, 1'b0, 8'h01);
    host_u.wr(8'h05, 8'h00);
    rchk(8'h05, 1'b0, 8'h00);
    rchk(8'h08, 1'b0, b);
    host_u.wr(8'h0A, 8'h18);
    rchk(8'h0A, 1'b1, 8'h08);
    for (int a = 4; a <= 7; a++) rchk(8'(a), 1'b0, 8'h00);
  endtask : sc_push_pop
  // store fills, 130 losses saturate the tally, then overwrite drops the oldest
  task automatic sc_full();
    logic [7:0] b;
    b = nxt_smp;
    push(386);
    rchk(8'h06, 1'b1, 8'hFF);
    rchk(8'h04, 1'b1, 8'h00);
    rchk(8'h07, 1'b0, 8'h00);
    rchk(8'h08, 1'b0, b);
    rchk(8'h06, 1'b0, 8'h7F);
    host_u.wr(8'h0A, 8'h0A);
    push(2);
    rchk(8'h05, 1'b0, 8'h02);
    rchk(8'h04, 1'b0, 8'h02);
    rchk(8'h06, 1'b0, 8'hFF);
    rchk(8'h08, 1'b0, 8'(b + 2));
    host_u.wr(8'h0A, 8'h18);
  endtask : sc_full
  task automatic sc_near_full();
    host_u.wr(8'h09, 8'hFD);
    rchk(8'h09, 1'b0, 8'hFD);
    rchk(8'h00, 1'b0, 8'h00);
    push(2);
    chk({7'h00, near_full_flag}, 8'h00);
    push(1);
    chk({7'h00, near_full_flag}, 8'h01);
    rchk(8'h00, 1'b0, 8'hC0);
    push(1);
    chk({7'h00, near_full_flag}, 8'h01);
    host_u.wr(8'h0A, 8'h0C);
    rchk(8'h00, 1'b0, 8'hC0);
    push(1);
    chk({7'h00, near_full_flag}, 8'h00);
  endtask : sc_near_full
  task automatic sc_flags();
    host_u.wr(8'h0A, 8'h00);
    pulse_frame();
    rchk(8'h08, 1'b0, 8'(nxt_smp - 5));
    chk({7'h00, frame_done_flag}, 8'h01);
    chk({7'h00, data_wait_flag}, 8'h01);
    rchk(8'h00, 1'b0, 8'h48);
    host_u.wr(8'h0A, 8'h08);
    pulse_frame();
    rchk(8'h08, 1'b0, 8'(nxt_smp - 4));
    chk({7'h00, frame_done_flag}, 8'h00);
    chk({7'h00, data_wait_flag}, 8'h00);
  endtask : sc_flags
  //////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  // watchdog: the whole run needs about 1000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    test_done();
  end
  initial begin
    rst_n      = 1'b0;
    smp_valid  = 1'b0;
    smp_data   = 8'h00;
    frame_done = 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    sc_reset_values();
    sc_push_pop();
    sc_full();
    sc_near_full();
    sc_flags();
    test_done();
  end
endmodule : sfc_sample_fifo_control_test
`default_nettype wire
